//--- hdl/vdsr_pkg.sv
// Purpose: shared constants for the video decoder status register block
// Assumes: 32-bit AHB-Lite register bus, one word per register
// Notes:   bit positions of the status byte are fixed by the decoder
package vdsr_pkg;

  // register byte offsets
  localparam logic [7:0] STATUS_OFS   = 8'h00;
  localparam logic [7:0] CTRL_OFS     = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;

  // status byte layout
  localparam int ST_VIDEO_PRESENT    = 7;
  localparam int ST_HLOCK   = 6;
  localparam int ST_FIELD   = 5;
  localparam int ST_STD625  = 4;
  localparam int ST_XTAL    = 3;
  localparam int ST_CAPTION = 2;
  localparam int ST_LUMA    = 1;
  localparam int ST_CHROMA  = 0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // control register layout
  localparam int CTRL_LUMA_SLEEP   = 0;
  localparam int CTRL_CHROMA_SLEEP = 1;
  localparam int CTRL_AUTO_FMT     = 2;
  localparam int CTRL_XTAL_SEL     = 3;
  localparam int CTRL_W            = 4;
  localparam logic [3:0] CTRL_RESET = 4'h4;

  // interrupt status / mask layout
  localparam int IRQ_CHROMA  = 0;
  localparam int IRQ_LUMA    = 1;
  localparam int IRQ_CAPTION = 2;
  localparam int IRQ_HLOCK   = 3;
  localparam int IRQ_VIDEO_PRESENT    = 4;
  localparam int IRQ_STD     = 5;
  localparam int IRQ_W       = 6;
  localparam logic [5:0] IRQ_RESET = 6'h00;

  // consecutive-event counts
  localparam int          RUN_W          = 6;
  localparam logic [5:0]  VIDEO_PRESENT_MISS_RUN  = 6'h1f;
  localparam logic [5:0]  HLOCK_RUN      = 6'h20;
  localparam logic [5:0]  STD_RUN        = 6'h20;
  localparam logic signed [7:0] HSYNC_TOL = 8'sh01;

  // field detector line position counter
  localparam int POS_W = 12;

  typedef enum logic {
    VDSR_UNLOCKED = 1'b0,
    VDSR_LOCKED   = 1'b1
  } vdsr_lock_t;

endpackage : vdsr_pkg

//--- hdl/vdsr_streak.sv
// Purpose: counts consecutive qualifying steps and pulses when a run completes
// Assumes: step is a one-cycle enable pulse
// Notes:   a step without hit restarts the run; completion restarts it too
module vdsr_streak
  import vdsr_pkg::*;
(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             step,
  input  wire logic             hit,
  input  wire logic [RUN_W-1:0] target,
  output logic                  done
);

  logic [RUN_W-1:0] run_reg;
  logic             last;

  assign last = (run_reg == target - 6'h01);
  assign done = step && hit && last;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_reg <= '0;
    end else if (step) begin
      if (!hit || last) begin
        run_reg <= '0;
      end else begin
        run_reg <= run_reg + 6'h01;
      end
    end
  end

endmodule : vdsr_streak

//--- hdl/vdsr_field_detect.sv
// Purpose: tells odd from even field by where vertical timing falls in a line
// Assumes: both timing outputs active low and synchronous to hclk
// Notes:   a vertical fall near mid-line marks an even field
module vdsr_field_detect
  import vdsr_pkg::*;
(
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic horizontal_timing_out_n,
  input  wire logic vertical_timing_out_n,
  output logic      field_even
);

  logic [POS_W-1:0] pos_reg;
  logic [POS_W-1:0] len_reg;
  logic             h_prev_reg;
  logic             v_prev_reg;
  logic             h_fall;
  logic             v_fall;
  logic             mid_line;

  assign h_fall   = h_prev_reg && !horizontal_timing_out_n;
  assign v_fall   = v_prev_reg && !vertical_timing_out_n;
  assign mid_line = (pos_reg >= (len_reg >> 2)) &&
                    (pos_reg <  (len_reg - (len_reg >> 2)));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      h_prev_reg <= 1'b1;
      v_prev_reg <= 1'b1;
    end else begin
      h_prev_reg <= horizontal_timing_out_n;
      v_prev_reg <= vertical_timing_out_n;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg <= '0;
      len_reg <= '0;
    end else if (h_fall) begin
      pos_reg <= '0;
      len_reg <= pos_reg;
    end else if (pos_reg != '1) begin
      pos_reg <= pos_reg + 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      field_even <= 1'b0;
    end else if (v_fall) begin
      field_even <= mid_line;
    end
  end

endmodule : vdsr_field_detect

//--- hdl/vdsr_status.sv
// Purpose: decoder device status byte with sticky flags, on an AHB-Lite slave
// Assumes: sensor inputs synchronous to hclk; single word transfers only
// Notes:   zero wait states; hresp is always OKAY; unmapped reads give zero
//
// Design decision made here: the AHB-Lite slave port.

module vdsr_status
  import vdsr_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              line_end,
  input  wire logic              hsync_detected,
  input  wire logic signed [7:0] hsync_offset,
  input  wire logic              horizontal_timing_out_n,
  input  wire logic              vertical_timing_out_n,
  input  wire logic              field_end,
  input  wire logic              field_is_625,
  input  wire logic              caption_fifo_half,
  input  wire logic              luma_adc_overflow,
  input  wire logic              chroma_adc_overflow,
  output logic                   irq
);

  logic                  addr_ok;
  logic                  wr_pend_reg;
  logic [7:0]            wr_addr_reg;
  logic [7:0]            rd_addr;
  logic                  status_wr;
  logic                  ctrl_wr;
  logic                  istat_wr;
  logic                  imask_wr;
  logic [31:0]           rd_word;

  logic [CTRL_W-1:0]     ctrl_reg;
  logic                  luma_sleep;
  logic                  chroma_sleep;
  logic                  auto_fmt;

  logic                  video_present_reg;
  vdsr_lock_t            lock_reg;
  logic                  line_standard_625_reg;
  logic                  caption_pairs_ready_reg;
  logic                  luma_overflow_reg;
  logic                  chroma_overflow_reg;
  logic                  crystal_port_selected;
  logic                  field_even;
  logic [7:0]            status_word;

  logic                  sync_seen_reg;
  logic                  good_line_reg;
  logic                  line_has_sync;
  logic                  miss_done;
  logic                  lock_done;
  logic                  std_done;
  logic                  cap_prev_reg;
  logic                  cap_rise;

  logic [IRQ_W-1:0]      irq_stat_reg;
  logic [IRQ_W-1:0]      irq_mask_reg;
  logic [IRQ_W-1:0]      irq_event;
  logic                  video_present_change;

  function automatic logic offset_in_tol(input logic signed [7:0] ofs);
    offset_in_tol = (ofs >= -HSYNC_TOL) && (ofs <= HSYNC_TOL);
  endfunction : offset_in_tol

  // bus slave: never stalls, so any access is taken at any time
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;
  assign rd_addr   = haddr[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && hwrite;
      if (addr_ok && hwrite) begin
        wr_addr_reg <= haddr[7:0];
      end
    end
  end

  assign status_wr = wr_pend_reg && (wr_addr_reg == STATUS_OFS);
  assign ctrl_wr   = wr_pend_reg && (wr_addr_reg == CTRL_OFS);
  assign istat_wr  = wr_pend_reg && (wr_addr_reg == IRQ_STAT_OFS);
  assign imask_wr  = wr_pend_reg && (wr_addr_reg == IRQ_MASK_OFS);

  // read data is built in the address phase and registered for the data phase
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (rd_addr)
      STATUS_OFS:   rd_word[7:0]        = status_word;
      CTRL_OFS:     rd_word[CTRL_W-1:0] = ctrl_reg;
      IRQ_STAT_OFS: rd_word[IRQ_W-1:0]  = irq_stat_reg;
      IRQ_MASK_OFS: rd_word[IRQ_W-1:0]  = irq_mask_reg;
      default:      rd_word = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_ok && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_reg <= hwdata[CTRL_W-1:0];
    end
  end

  assign luma_sleep   = ctrl_reg[CTRL_LUMA_SLEEP];
  assign chroma_sleep = ctrl_reg[CTRL_CHROMA_SLEEP];
  assign auto_fmt     = ctrl_reg[CTRL_AUTO_FMT];

  // per-line sync bookkeeping, cleared at each line end
  assign line_has_sync = sync_seen_reg || hsync_detected;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_seen_reg <= 1'b0;
      good_line_reg <= 1'b0;
    end else if (line_end) begin
      sync_seen_reg <= 1'b0;
      good_line_reg <= 1'b0;
    end else if (hsync_detected) begin
      sync_seen_reg <= 1'b1;
      good_line_reg <= offset_in_tol(hsync_offset);
    end
  end

  vdsr_streak u_miss (
    .hclk    (hclk),
    .hresetn (hresetn),
    .step    (line_end),
    .hit     (!line_has_sync),
    .target  (VIDEO_PRESENT_MISS_RUN),
    .done    (miss_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      video_present_reg <= 1'b0;
    end else if (line_end && line_has_sync) begin
      video_present_reg <= 1'b1;
    end else if (miss_done) begin
      video_present_reg <= 1'b0;
    end
  end

  // a run of good lines locks, a run of bad lines unlocks
  vdsr_streak u_lock (
    .hclk    (hclk),
    .hresetn (hresetn),
    .step    (line_end),
    .hit     ((lock_reg == VDSR_LOCKED) ? !good_line_reg : good_line_reg),
    .target  (HLOCK_RUN),
    .done    (lock_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_reg <= VDSR_UNLOCKED;
    end else if (lock_done) begin
      unique case (lock_reg)
        VDSR_UNLOCKED: lock_reg <= VDSR_LOCKED;
        VDSR_LOCKED:   lock_reg <= VDSR_UNLOCKED;
      endcase
    end
  end

  vdsr_field_detect u_field (
    .hclk                    (hclk),
    .hresetn                 (hresetn),
    .horizontal_timing_out_n (horizontal_timing_out_n),
    .vertical_timing_out_n   (vertical_timing_out_n),
    .field_even              (field_even)
  );

  // filtered so a noisy count cannot flip the standard
  vdsr_streak u_std (
    .hclk    (hclk),
    .hresetn (hresetn),
    .step    (field_end),
    .hit     (field_is_625 != line_standard_625_reg),
    .target  (STD_RUN),
    .done    (std_done)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_standard_625_reg <= 1'b0;
    end else if (std_done) begin
      line_standard_625_reg <= !line_standard_625_reg;
    end
  end

  assign crystal_port_selected = auto_fmt ? line_standard_625_reg
                                          : ctrl_reg[CTRL_XTAL_SEL];

  assign cap_rise = caption_fifo_half && !cap_prev_reg;

  // sticky flags: a set in the same cycle as a clearing write wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_prev_reg            <= 1'b0;
      caption_pairs_ready_reg <= 1'b0;
      luma_overflow_reg       <= 1'b0;
      chroma_overflow_reg     <= 1'b0;
    end else begin
      cap_prev_reg <= caption_fifo_half;
      if (cap_rise) begin
        caption_pairs_ready_reg <= 1'b1;
      end else if (status_wr) begin
        caption_pairs_ready_reg <= 1'b0;
      end
      if (luma_adc_overflow) begin
        luma_overflow_reg <= 1'b1;
      end else if (status_wr) begin
        luma_overflow_reg <= 1'b0;
      end
      if (chroma_adc_overflow) begin
        chroma_overflow_reg <= 1'b1;
      end else if (status_wr) begin
        chroma_overflow_reg <= 1'b0;
      end
    end
  end

  // live bits come straight from their sources
  always_comb begin
    status_word             = STATUS_RESET;
    status_word[ST_VIDEO_PRESENT]    = video_present_reg;
    status_word[ST_HLOCK]   = (lock_reg == VDSR_LOCKED);
    status_word[ST_FIELD]   = field_even;
    status_word[ST_STD625]  = line_standard_625_reg;
    status_word[ST_XTAL]    = crystal_port_selected;
    status_word[ST_CAPTION] = caption_pairs_ready_reg;
    status_word[ST_LUMA]    = luma_overflow_reg || luma_sleep;
    status_word[ST_CHROMA]  = chroma_overflow_reg || chroma_sleep;
  end

  // interrupt: sticky write-one-to-clear, set wins over clear
  assign video_present_change = (line_end && line_has_sync && !video_present_reg) ||
                       (miss_done && video_present_reg);

  always_comb begin
    irq_event              = '0;
    irq_event[IRQ_CHROMA]  = chroma_adc_overflow;
    irq_event[IRQ_LUMA]    = luma_adc_overflow;
    irq_event[IRQ_CAPTION] = cap_rise;
    irq_event[IRQ_HLOCK]   = lock_done;
    irq_event[IRQ_VIDEO_PRESENT]    = video_present_change;
    irq_event[IRQ_STD]     = std_done;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= IRQ_RESET;
    end else if (istat_wr) begin
      irq_stat_reg <= (irq_stat_reg & ~hwdata[IRQ_W-1:0]) | irq_event;
    end else begin
      irq_stat_reg <= irq_stat_reg | irq_event;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_mask_reg <= IRQ_RESET;
    end else if (imask_wr) begin
      irq_mask_reg <= hwdata[IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // checks
  logic [RUN_W-1:0] miss_run_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      miss_run_reg <= '0;
    end else if (line_end) begin
      miss_run_reg <= line_has_sync ? '0 : miss_run_reg + 6'h01;
    end
  end

  sequence s_status_read;
    addr_ok && !hwrite && (haddr[7:0] == STATUS_OFS);
  endsequence

  sequence s_status_write;
    addr_ok && hwrite && (haddr[7:0] == STATUS_OFS) ##1 wr_pend_reg;
  endsequence

  a_bus_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok |=> hreadyout && !hresp)
    else $error("slave stalled or errored");

  a_reset_clear: assert property (@(posedge hclk)
    $rose(hresetn) |-> (status_word == {6'h00, luma_sleep, chroma_sleep}))
    else $error("status not zero after reset");

  a_read_layout: assert property (@(posedge hclk) disable iff (!hresetn)
    s_status_read |=> hrdata == {24'h000000, $past(status_word)})
    else $error("status read does not match bit layout");

  a_ovf_latch: assert property (@(posedge hclk) disable iff (!hresetn)
    luma_overflow_reg && !status_wr |=> luma_overflow_reg)
    else $error("luma overflow lost without a write");

  a_field_live: assert property (@(posedge hclk) disable iff (!hresetn)
    status_word[ST_FIELD] == field_even)
    else $error("field bit not live");

  a_present_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    line_end && !line_has_sync && miss_run_reg == 6'h1e |=> !video_present_reg)
    else $error("video present not dropped after 31 empty lines");

  a_lock_write: assert property (@(posedge hclk) disable iff (!hresetn)
    status_wr && !lock_done |=> $stable(lock_reg))
    else $error("host write changed lock flag");

  a_std_filter: assert property (@(posedge hclk) disable iff (!hresetn)
    $changed(line_standard_625_reg) |-> $past(field_end && field_is_625 !=
                                              line_standard_625_reg))
    else $error("line standard changed without a field vote");

  a_xtal_auto: assert property (@(posedge hclk) disable iff (!hresetn)
    auto_fmt |-> status_word[ST_XTAL] == status_word[ST_STD625])
    else $error("crystal bit differs from line bit under auto");

  a_caption_set: assert property (@(posedge hclk) disable iff (!hresetn)
    cap_rise |=> caption_pairs_ready_reg)
    else $error("caption bit not set on half full");

  a_luma_clear: assert property (@(posedge hclk) disable iff (!hresetn)
    s_status_write ##0 !luma_adc_overflow |=> !luma_overflow_reg)
    else $error("luma overflow not cleared by write");

  a_luma_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    luma_sleep |-> status_word[ST_LUMA])
    else $error("luma bit not forced in sleep");

  a_chroma_set: assert property (@(posedge hclk) disable iff (!hresetn)
    chroma_adc_overflow |=> chroma_overflow_reg)
    else $error("chroma overflow not set");

  a_chroma_sleep: assert property (@(posedge hclk) disable iff (!hresetn)
    chroma_sleep |-> status_word[ST_CHROMA])
    else $error("chroma bit not forced in sleep");

endmodule : vdsr_status

//--- dv/vdsr_host.sv
// Purpose: host processor model issuing AHB-Lite single word transfers
// Assumes: one slave, whose hreadyout is the bus hready
// Notes:   waits are bounded; ok drops when a wait runs out
module vdsr_host (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    hsel   = 1'h0;
    haddr  = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = 3'h2;
    hwdata = 32'h0;
  end

  task automatic wait_ready(inout bit ok);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'h1 && n < 50);
    if (hready !== 1'h1) ok = 1'h0;
  endtask : wait_ready

  // caller enters just after a rising edge
  task automatic xfer(input logic [7:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] rd, output bit ok);
    ok = 1'h1;
    hsel   <= 1'h1;
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_ready(ok);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    wait_ready(ok);
    rd = hrdata;
    // released data lines must not keep looking valid
    hwdata <= ~wd;
  endtask : xfer
endmodule : vdsr_host

//--- dv/vdsr_status_bench.sv
// Purpose: self-checking bench for the decoder status register block
// Assumes: zero wait state slave; sensor strobes driven as one-cycle pulses
// Notes:   expectations come from the status layout and run lengths
module video_decoder_status_register_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import vdsr_pkg::*;

  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0]       haddr, hwdata, hrdata;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic              line_end, hsync_detected, field_end, field_is_625;
  logic signed [7:0] hsync_offset;
  logic              hz_n, vt_n, caption_fifo_half, luma_ovf, chroma_ovf;
  int                err_total, checked;

  typedef struct {logic l; logic c; logic p; logic [31:0] e;} vdsr_row_t;
  vdsr_row_t rows [5] = '{'{1'h1, 1'h0, 1'h0, 32'h2}, '{1'h0, 1'h1, 1'h0, 32'h1},
                          '{1'h0, 1'h0, 1'h1, 32'h4}, '{1'h1, 1'h1, 1'h1, 32'h7},
                          '{1'h0, 1'h0, 1'h0, 32'h0}};

  initial begin
    hclk = 1'h0;
    forever #2.5 hclk = ~hclk;
  end

  vdsr_status dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .line_end(line_end),
    .hsync_detected(hsync_detected), .hsync_offset(hsync_offset),
    .horizontal_timing_out_n(hz_n), .vertical_timing_out_n(vt_n), .field_end(field_end),
    .field_is_625(field_is_625), .caption_fifo_half(caption_fifo_half),
    .luma_adc_overflow(luma_ovf), .chroma_adc_overflow(chroma_ovf), .irq(irq));

  vdsr_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  task automatic close_out();
    if (err_total == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic rw(input logic [7:0] a, input logic w, input logic [31:0] wd,
                    output logic [31:0] rd);
    bit ok;
    host.xfer(a, w, wd, rd, ok);
    if (!ok) begin
      err_total++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      close_out();
    end
  endtask : rw

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                        input string what);
    logic [31:0] d;
    rw(a, 1'h0, 32'h0, d);
    check(d & m, e, what);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    rw(a, 1'h1, d, x);
    @(posedge hclk);
  endtask : wr

  task automatic lines(input int n, input logic sync, input logic signed [7:0] off);
    repeat (n) begin
      hsync_detected <= sync;
      hsync_offset   <= off;
      @(posedge hclk);
      hsync_detected <= 1'h0;
      line_end       <= 1'h1;
      @(posedge hclk);
      line_end       <= 1'h0;
    end
  endtask : lines

  task automatic fields(input int n, input logic is625);
    repeat (n) begin
      field_is_625 <= is625;
      field_end    <= 1'h1;
      @(posedge hclk);
      field_end    <= 1'h0;
      @(posedge hclk);
    end
  endtask : fields

  // two horizontal falls 40 clocks apart, then a vertical fall pos clocks later
  task automatic field_probe(input int pos);
    hz_n <= 1'h0;
    repeat (2) @(posedge hclk);
    hz_n <= 1'h1;
    repeat (38) @(posedge hclk);
    hz_n <= 1'h0;
    repeat (2) @(posedge hclk);
    hz_n <= 1'h1;
    repeat (pos - 2) @(posedge hclk);
    vt_n <= 1'h0;
    repeat (4) @(posedge hclk);
    vt_n <= 1'h1;
  endtask : field_probe

  initial begin
    repeat (20000) @(posedge hclk);
    err_total++;
    $display("CHECK FAILED at %0t: run limit reached", $time);
    close_out();
  end

  initial begin
    {hresetn, line_end, hsync_detected, field_end, field_is_625} = 5'h0;
    {caption_fifo_half, luma_ovf, chroma_ovf} = 3'h0;
    hsync_offset = 8'sh00;
    {hz_n, vt_n} = 2'h3;
    err_total = 0;
    checked = 0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rd_chk(STATUS_OFS, 32'hff, {24'h0, STATUS_RESET}, "status reset");
    check({31'h0, hresp}, 32'h0, "okay response");
    rd_chk(CTRL_OFS, 32'hf, {28'h0, CTRL_RESET}, "ctrl reset");
    wr(IRQ_MASK_OFS, 32'h7);
    foreach (rows[i]) begin
      luma_ovf          <= rows[i].l;
      chroma_ovf        <= rows[i].c;
      caption_fifo_half <= rows[i].p;
      @(posedge hclk);
      {luma_ovf, chroma_ovf, caption_fifo_half} <= 3'h0;
      @(posedge hclk);
      rd_chk(STATUS_OFS, 32'h7, rows[i].e, "sticky set");
      rd_chk(IRQ_STAT_OFS, 32'h7, rows[i].e, "irq status");
      check({31'h0, irq}, {31'h0, rows[i].e != 32'h0}, "irq raised");
      wr(STATUS_OFS, 32'hff);
      wr(IRQ_STAT_OFS, 32'h3f);
      rd_chk(STATUS_OFS, 32'hff, 32'h0, "write clears");
      check({31'h0, irq}, 32'h0, "irq cleared");
    end
    // masked event must latch but not interrupt
    wr(IRQ_MASK_OFS, 32'h0);
    luma_ovf <= 1'h1;
    @(posedge hclk);
    luma_ovf <= 1'h0;
    @(posedge hclk);
    check({31'h0, irq}, 32'h0, "irq masked");
    wr(IRQ_MASK_OFS, 32'h2);
    check({31'h0, irq}, 32'h1, "irq unmasked");
    wr(IRQ_STAT_OFS, 32'h2);
    check({31'h0, irq}, 32'h0, "irq w1c");
    wr(STATUS_OFS, 32'h0);
    wr(CTRL_OFS, 32'h3);
    rd_chk(STATUS_OFS, 32'h3, 32'h3, "sleep forces ovf");
    rd_chk(CTRL_OFS, 32'hf, 32'h3, "ctrl readback");
    wr(CTRL_OFS, 32'h4);
    rd_chk(STATUS_OFS, 32'h3, 32'h0, "sleep released");
    lines(1, 1'h1, 8'sh00);
    rd_chk(STATUS_OFS, 32'hc0, 32'h80, "present");
    lines(30, 1'h1, -8'sh01);
    rd_chk(STATUS_OFS, 32'hc0, 32'h80, "31 good lines");
    lines(1, 1'h1, 8'sh01);
    rd_chk(STATUS_OFS, 32'hc0, 32'hc0, "locked");
    wr(STATUS_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'hc0, 32'hc0, "lock ignores write");
    lines(31, 1'h1, 8'sh02);
    rd_chk(STATUS_OFS, 32'hc0, 32'hc0, "31 bad lines");
    lines(1, 1'h1, -8'sh02);
    rd_chk(STATUS_OFS, 32'hc0, 32'h80, "unlocked");
    lines(30, 1'h0, 8'sh00);
    rd_chk(STATUS_OFS, 32'hc0, 32'h80, "30 lines no sync");
    lines(1, 1'h0, 8'sh00);
    rd_chk(STATUS_OFS, 32'hc0, 32'h00, "not present");
    fields(31, 1'h1);
    rd_chk(STATUS_OFS, 32'h18, 32'h00, "31 fields");
    fields(1, 1'h1);
    rd_chk(STATUS_OFS, 32'h18, 32'h18, "625 auto crystal");
    // presence, lock and standard changes have all been seen by now
    rd_chk(IRQ_STAT_OFS, 32'h3f, 32'h38, "change events latched");
    wr(CTRL_OFS, 32'h0);
    rd_chk(STATUS_OFS, 32'h18, 32'h10, "manual port 0");
    wr(CTRL_OFS, 32'h8);
    rd_chk(STATUS_OFS, 32'h18, 32'h18, "manual port 1");
    wr(CTRL_OFS, 32'h4);
    field_probe(20);
    rd_chk(STATUS_OFS, 32'h20, 32'h20, "even field");
    field_probe(4);
    rd_chk(STATUS_OFS, 32'h20, 32'h00, "odd field");
    rd_chk(8'h10, 32'hffffffff, 32'h0, "unmapped read");
    luma_ovf <= 1'h1;
    @(posedge hclk);
    luma_ovf <= 1'h0;
    hresetn  <= 1'h0;
    repeat (3) @(posedge hclk);
    hresetn  <= 1'h1;
    @(posedge hclk);
    rd_chk(STATUS_OFS, 32'hff, 32'h0, "mid-run reset");
    close_out();
  end
endmodule : video_decoder_status_register_bench
